//--- ucr_pkg.sv
// Package for the upconverter control register slice: offsets, field
// layouts, reset values and the packed carriers shared by the design.
// Assumes the serial port decoder delivers whole register words.
`default_nettype none

package ucr_pkg;

	// ************************************************************
	// Register addresses on the serial control port
	// ************************************************************
	localparam logic [4:0] ADDR_CLK_PATH_CONFIG = 5'h02;
	localparam logic [4:0] ADDR_DAC_CURRENT     = 5'h03;
	localparam logic [4:0] ADDR_AUTO_COMMIT     = 5'h04;
	localparam logic [4:0] ADDR_RAM_SEG_ZERO    = 5'h05;
	localparam logic [4:0] ADDR_RAM_SEG_ONE     = 5'h06;
	localparam logic [4:0] ADDR_AMP_CONTROL     = 5'h09;

	// ************************************************************
	// Reset values and writable-bit masks
	// ************************************************************
	localparam logic [31:0] RST_CLK_PATH_CONFIG = 32'h1738_4000;
	localparam logic [31:0] MSK_CLK_PATH_CONFIG = 32'h3738_c1fe;
	localparam logic [31:0] RST_DAC_CURRENT     = 32'h0000_00ff;
	localparam logic [31:0] MSK_DAC_CURRENT     = 32'h0000_00ff;
	localparam logic [31:0] RST_AUTO_COMMIT     = 32'h0fff_ffff;
	localparam logic [47:0] RST_RAM_SEG         = 48'h0000_0000_0000;
	localparam logic [47:0] MSK_RAM_SEG         = 48'hffff_ffc0_ffc7;
	localparam logic [31:0] RST_AMP_CONTROL     = 32'h0000_0000;

	// ************************************************************
	// Control bits taken from the neighbouring control registers
	// ************************************************************
	localparam int CF1_RAM_ENABLE   = 31;
	localparam int CF1_MANUAL_KEY   = 23;
	localparam int CF1_AMP_ENABLE   = 9;
	localparam int CF1_AUTO_KEY     = 8;
	localparam int CF2_AUTO_COMMIT  = 23;

	// ************************************************************
	// Packed carriers matching the register layouts
	// ************************************************************
	typedef struct packed {
		logic [1:0] open_hi;
		logic [1:0] refout_drive_setting;
		logic       open_27;
		logic [2:0] oscillator_band_select;
		logic [1:0] open_23;
		logic [2:0] charge_pump_current;
		logic [2:0] open_18;
		logic       divider_bypass;
		logic       divider_reset_n;
		logic [4:0] open_13;
		logic       pll_enable;
		logic [6:0] feedback_modulus;
		logic       open_0;
	} ucr_clk_cfg_t;

	typedef struct packed {
		logic [15:0] step_rate;
		logic [9:0]  end_addr;
		logic [5:0]  open_21;
		logic [9:0]  start_addr;
		logic [2:0]  open_5;
		logic [2:0]  playback_mode;
	} ucr_ram_seg_t;

	typedef struct packed {
		logic [15:0] ramp_rate;
		logic [13:0] amplitude_scale_factor;
		logic [1:0]  step_size;
	} ucr_amp_t;

endpackage

`default_nettype wire

//--- ucr_regs.sv
// Upconverter control register slice: clock path, DAC current, automatic
// commit pacing, RAM segment descriptors and amplitude keying register.
// Assumes a serial port decoder on sys_clk that presents full words with a
// one-cycle write strobe, and control register bits from the same clock.
//
// Function
// - Clock path register at 0x02, bits 29:28 drive setting, reset 01b.
// - Clock path bits 26:24 choose oscillator band, reset 111b.
// - Clock path bits 21:19 choose charge pump current, reset 111b.
// - Bit 15 zero uses input divider, one bypasses it; reset zero.
// - Bit 14 is divider run, zero holds divider reset; reset one.
// - Bit 8 zero bypasses PLL, one enables multiplication; reset zero.
// - Bits 7:1 give PLL feedback modulus, reset all zeros.
// - Register 0x03 bits 7:0 set DAC full-scale current, reset 0xff.
// - Commit-rate and segment zero writes act at once, no commit needed.
// - Commit-rate paces automatic commits only when control two bit 23 set.
// - Segment zero applies on trigger rising edge with control one bit 31.
// - Segment one at 0x06 applies on trigger falling edge with bit 31.
// - Segment bits 47:32 hold the address step rate.
// - Segment bits 31:22 end address, bits 15:6 start address.
// - Segment bits 2:0 carry the playback mode.
// - Amplitude register at 0x09 acts only while control one bit 9 set.
// - Amplitude bits 31:16 ramp rate, effective only with bit 8 set.
// - Bits 8 and 23 clear: bits 15:2 are the scale factor directly.
// - Bit 8 clear, bit 23 set: scale applies only while keying pin high.
// - Bit 8 set: scale field is the ceiling for automatic keying.
// - Bits 1:0 choose step size, effective only with bit 8 set.
`timescale 1ns/1ps
`default_nettype none

module ucr_regs (
	// Clock and reset
	input  wire logic                  sys_clk,
	input  wire logic                  rst_n,
	// Register port from the serial decoder
	input  wire logic                  wr_en,
	input  wire logic [4:0]            wr_addr,
	input  wire logic [47:0]           wr_data,
	input  wire logic [4:0]            rd_addr,
	output logic      [47:0]           rd_data,
	// Commit strobe and neighbouring control bits
	input  wire logic                  io_update,
	input  wire logic [31:0]           control_function_one,
	input  wire logic [31:0]           control_function_two,
	// Device pins
	input  wire logic                  ram_segment_trigger,
	input  wire logic                  amplitude_keying_pin,
	// Clock path and DAC
	output ucr_pkg::ucr_clk_cfg_t      clk_cfg,
	output logic      [7:0]            dac_full_scale_current,
	output logic                       auto_commit_pulse,
	// RAM state machine descriptor
	output ucr_pkg::ucr_ram_seg_t      ram_seg,
	output logic                       ram_seg_load,
	// Amplitude keying controller
	output logic                       amp_active,
	output logic                       amp_auto_key,
	output logic      [13:0]           amplitude_scale_factor,
	output logic      [15:0]           amp_ramp_rate,
	output logic      [1:0]            amp_step_size
);

	// ************************************************************
	// Pin synchronisers
	// ************************************************************
	logic [2:0] trig_sync_ff;
	logic [2:0] nxt_trig_sync;
	logic [1:0] key_sync_ff;
	logic [1:0] nxt_key_sync;
	logic       trig_rise;
	logic       trig_fall;
	logic       key_level;

	// Two stages before use, a third for edge detection
	always_comb begin
		nxt_trig_sync = {trig_sync_ff[1:0], ram_segment_trigger};
		nxt_key_sync  = {key_sync_ff[0], amplitude_keying_pin};
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			trig_sync_ff <= 3'h0;
			key_sync_ff  <= 2'h0;
		end else begin
			trig_sync_ff <= nxt_trig_sync;
			key_sync_ff  <= nxt_key_sync;
		end
	end

	assign trig_rise = trig_sync_ff[1] & ~trig_sync_ff[2];
	assign trig_fall = ~trig_sync_ff[1] & trig_sync_ff[2];
	assign key_level = key_sync_ff[1];

	// ************************************************************
	// Automatic commit pacing
	// ************************************************************
	logic [31:0] rate_ff;
	logic [31:0] commit_cnt_ff;
	logic [31:0] nxt_commit_cnt;
	logic        auto_ff;
	logic        nxt_auto;
	logic        commit;

	// Counter runs only while the enable bit is set
	always_comb begin
		nxt_commit_cnt = 32'h0;
		nxt_auto       = 1'b0;
		if (control_function_two[ucr_pkg::CF2_AUTO_COMMIT]) begin
			if (commit_cnt_ff >= rate_ff) begin
				nxt_auto = 1'b1;
			end else begin
				nxt_commit_cnt = commit_cnt_ff + 32'h1;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			commit_cnt_ff <= 32'h0;
			auto_ff       <= 1'b0;
		end else begin
			commit_cnt_ff <= nxt_commit_cnt;
			auto_ff       <= nxt_auto;
		end
	end

	assign auto_commit_pulse = auto_ff;
	assign commit            = io_update | auto_ff;

	// ************************************************************
	// Register file: shadow copies, live copies, immediate registers
	// ************************************************************
	logic [31:0] cfg_sh_ff, nxt_cfg_sh, cfg_ff, nxt_cfg;
	logic [31:0] dac_sh_ff, nxt_dac_sh, dac_ff, nxt_dac;
	logic [31:0] amp_sh_ff, nxt_amp_sh, amp_ff, nxt_amp;
	logic [47:0] seg0_ff, nxt_seg0, seg1_sh_ff, nxt_seg1_sh, seg1_ff, nxt_seg1;
	logic [31:0] nxt_rate;
	logic        wr_cfg, wr_dac, wr_rate, wr_seg0, wr_seg1, wr_amp;

	assign wr_cfg  = wr_en && (wr_addr == ucr_pkg::ADDR_CLK_PATH_CONFIG);
	assign wr_dac  = wr_en && (wr_addr == ucr_pkg::ADDR_DAC_CURRENT);
	assign wr_rate = wr_en && (wr_addr == ucr_pkg::ADDR_AUTO_COMMIT);
	assign wr_seg0 = wr_en && (wr_addr == ucr_pkg::ADDR_RAM_SEG_ZERO);
	assign wr_seg1 = wr_en && (wr_addr == ucr_pkg::ADDR_RAM_SEG_ONE);
	assign wr_amp  = wr_en && (wr_addr == ucr_pkg::ADDR_AMP_CONTROL);

	// Writes land in shadows, rate and segment zero writes land live; commit copies shadows into live state
	always_comb begin
		nxt_cfg_sh  = cfg_sh_ff;
		nxt_dac_sh  = dac_sh_ff;
		nxt_amp_sh  = amp_sh_ff;
		nxt_seg1_sh = seg1_sh_ff;
		nxt_rate    = rate_ff;
		nxt_seg0    = seg0_ff;
		nxt_cfg     = cfg_ff;
		nxt_dac     = dac_ff;
		nxt_amp     = amp_ff;
		nxt_seg1    = seg1_ff;
		if (wr_cfg) begin
			nxt_cfg_sh = wr_data[31:0] & ucr_pkg::MSK_CLK_PATH_CONFIG;
		end
		if (wr_dac) begin
			nxt_dac_sh = wr_data[31:0] & ucr_pkg::MSK_DAC_CURRENT;
		end
		if (wr_amp) begin
			nxt_amp_sh = wr_data[31:0];
		end
		if (wr_seg1) begin
			nxt_seg1_sh = wr_data & ucr_pkg::MSK_RAM_SEG;
		end
		if (wr_rate) begin
			nxt_rate = wr_data[31:0];
		end
		if (wr_seg0) begin
			nxt_seg0 = wr_data & ucr_pkg::MSK_RAM_SEG;
		end
		if (commit) begin
			nxt_cfg  = cfg_sh_ff;
			nxt_dac  = dac_sh_ff;
			nxt_amp  = amp_sh_ff;
			nxt_seg1 = seg1_sh_ff;
		end
	end

	// Reset loads the documented defaults into both copies
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			cfg_sh_ff  <= ucr_pkg::RST_CLK_PATH_CONFIG;
			cfg_ff     <= ucr_pkg::RST_CLK_PATH_CONFIG;
			dac_sh_ff  <= ucr_pkg::RST_DAC_CURRENT;
			dac_ff     <= ucr_pkg::RST_DAC_CURRENT;
			amp_sh_ff  <= ucr_pkg::RST_AMP_CONTROL;
			amp_ff     <= ucr_pkg::RST_AMP_CONTROL;
			seg1_sh_ff <= ucr_pkg::RST_RAM_SEG;
			seg1_ff    <= ucr_pkg::RST_RAM_SEG;
			seg0_ff    <= ucr_pkg::RST_RAM_SEG;
			rate_ff    <= ucr_pkg::RST_AUTO_COMMIT;
		end else begin
			cfg_sh_ff  <= nxt_cfg_sh;
			cfg_ff     <= nxt_cfg;
			dac_sh_ff  <= nxt_dac_sh;
			dac_ff     <= nxt_dac;
			amp_sh_ff  <= nxt_amp_sh;
			amp_ff     <= nxt_amp;
			seg1_sh_ff <= nxt_seg1_sh;
			seg1_ff    <= nxt_seg1;
			seg0_ff    <= nxt_seg0;
			rate_ff    <= nxt_rate;
		end
	end

	// Live clock path fields; layout fixes each bit position
	assign clk_cfg                = ucr_pkg::ucr_clk_cfg_t'(cfg_ff);
	assign dac_full_scale_current = dac_ff[7:0];

	// ************************************************************
	// Read-back, one cycle after the address
	// ************************************************************
	logic [47:0] rd_ff;
	logic [47:0] nxt_rd;

	// Shadow values read back; unmapped addresses read zero
	always_comb begin
		case (rd_addr)
			ucr_pkg::ADDR_CLK_PATH_CONFIG: nxt_rd = {16'h0, cfg_sh_ff};
			ucr_pkg::ADDR_DAC_CURRENT:     nxt_rd = {16'h0, dac_sh_ff};
			ucr_pkg::ADDR_AUTO_COMMIT:     nxt_rd = {16'h0, rate_ff};
			ucr_pkg::ADDR_RAM_SEG_ZERO:    nxt_rd = seg0_ff;
			ucr_pkg::ADDR_RAM_SEG_ONE:     nxt_rd = seg1_sh_ff;
			ucr_pkg::ADDR_AMP_CONTROL:     nxt_rd = {16'h0, amp_sh_ff};
			default:                       nxt_rd = 48'h0;
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			rd_ff <= 48'h0;
		end else begin
			rd_ff <= nxt_rd;
		end
	end

	assign rd_data = rd_ff;

	// ************************************************************
	// RAM segment selection by trigger edges
	// ************************************************************
	logic [47:0] seg_ff;
	logic [47:0] nxt_seg;
	logic        load_ff;
	logic        nxt_load;
	logic        ram_en;

	assign ram_en = control_function_one[ucr_pkg::CF1_RAM_ENABLE];

	// Rising edge selects segment zero, falling edge segment one
	always_comb begin
		nxt_seg  = seg_ff;
		nxt_load = 1'b0;
		if (ram_en && trig_rise) begin
			nxt_seg  = seg0_ff;
			nxt_load = 1'b1;
		end else if (ram_en && trig_fall) begin
			nxt_seg  = seg1_ff;
			nxt_load = 1'b1;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			seg_ff  <= ucr_pkg::RST_RAM_SEG;
			load_ff <= 1'b0;
		end else begin
			seg_ff  <= nxt_seg;
			load_ff <= nxt_load;
		end
	end

	// Step rate, end, start and mode fields by layout
	assign ram_seg      = ucr_pkg::ucr_ram_seg_t'(seg_ff);
	assign ram_seg_load = load_ff;

	// ************************************************************
	// Amplitude scale selection
	// ************************************************************
	ucr_pkg::ucr_amp_t amp_live;
	logic [13:0]       scale_ff, nxt_scale;
	logic [15:0]       ramp_ff, nxt_ramp;
	logic [1:0]        step_ff, nxt_step;
	logic              act_ff, nxt_act, auto_key_ff, nxt_auto_key;

	assign amp_live = ucr_pkg::ucr_amp_t'(amp_ff);

	// Manual, pin-gated or ceiling use of the scale field
	always_comb begin
		nxt_act      = control_function_one[ucr_pkg::CF1_AMP_ENABLE];
		nxt_auto_key = 1'b0;
		nxt_scale    = 14'h0;
		nxt_ramp     = 16'h0;
		nxt_step     = 2'h0;
		if (nxt_act) begin
			if (control_function_one[ucr_pkg::CF1_AUTO_KEY]) begin
				nxt_auto_key = 1'b1;
				nxt_scale    = amp_live.amplitude_scale_factor;
				nxt_ramp     = amp_live.ramp_rate;
				nxt_step     = amp_live.step_size;
			end else if (control_function_one[ucr_pkg::CF1_MANUAL_KEY]) begin
				nxt_scale = key_level ? amp_live.amplitude_scale_factor : 14'h0;
			end else begin
				nxt_scale = amp_live.amplitude_scale_factor;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			act_ff      <= 1'b0;
			auto_key_ff <= 1'b0;
			scale_ff    <= 14'h0;
			ramp_ff     <= 16'h0;
			step_ff     <= 2'h0;
		end else begin
			act_ff      <= nxt_act;
			auto_key_ff <= nxt_auto_key;
			scale_ff    <= nxt_scale;
			ramp_ff     <= nxt_ramp;
			step_ff     <= nxt_step;
		end
	end

	assign amp_active             = act_ff;
	assign amp_auto_key           = auto_key_ff;
	assign amplitude_scale_factor = scale_ff;
	assign amp_ramp_rate          = ramp_ff;
	assign amp_step_size          = step_ff;

	// ************************************************************
	// Assertions
	// ************************************************************
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	sequence s_trig_rise;
		ram_en && trig_rise;
	endsequence
	sequence s_seg0_out;
		ram_seg_load && (seg_ff == $past(seg0_ff));
	endsequence
	property p_commit_copies;
		commit |=> (cfg_ff == $past(cfg_sh_ff)) && (dac_ff == $past(dac_sh_ff));
	endproperty
	a_commit_copies: assert property (p_commit_copies) else $error("commit did not copy shadows");
	property p_hold_no_commit;
		!commit |=> $stable(cfg_ff) && $stable(amp_ff) && $stable(seg1_ff);
	endproperty
	a_hold_no_commit: assert property (p_hold_no_commit) else $error("live register moved without commit");
	property p_rate_now;
		wr_rate |=> rate_ff == $past(wr_data[31:0]);
	endproperty
	a_rate_now: assert property (p_rate_now) else $error("rate write not immediate");
	property p_auto_gate;
		auto_commit_pulse |-> $past(control_function_two[ucr_pkg::CF2_AUTO_COMMIT]);
	endproperty
	a_auto_gate: assert property (p_auto_gate) else $error("auto commit while disabled");
	property p_seg0_apply;
		s_trig_rise |=> s_seg0_out;
	endproperty
	a_seg0_apply: assert property (p_seg0_apply) else $error("segment zero not applied");
	property p_seg1_apply;
		ram_en && trig_fall |=> ram_seg_load && (seg_ff == $past(seg1_ff));
	endproperty
	a_seg1_apply: assert property (p_seg1_apply) else $error("segment one not applied");
	property p_seg_idle;
		!ram_en |=> !ram_seg_load && $stable(seg_ff);
	endproperty
	a_seg_idle: assert property (p_seg_idle) else $error("segment changed while RAM disabled");
	property p_scale_direct;
		control_function_one[9] && !control_function_one[8] && !control_function_one[23]
			|=> amplitude_scale_factor == $past(amp_live.amplitude_scale_factor);
	endproperty
	a_scale_direct: assert property (p_scale_direct) else $error("direct scale mismatch");
	property p_scale_pin;
		control_function_one[9] && !control_function_one[8] && control_function_one[23] && !key_level
			|=> amplitude_scale_factor == 14'h0;
	endproperty
	a_scale_pin: assert property (p_scale_pin) else $error("scale applied with keying pin low");
	property p_step_gate;
		!control_function_one[8] |=> amp_step_size == 2'h0 && amp_ramp_rate == 16'h0;
	endproperty
	a_step_gate: assert property (p_step_gate) else $error("step or ramp leaked in manual mode");
	property p_open_bits;
		rd_addr == ucr_pkg::ADDR_CLK_PATH_CONFIG |=> (rd_data[31:0] & ~ucr_pkg::MSK_CLK_PATH_CONFIG) == 32'h0;
	endproperty
	a_open_bits: assert property (p_open_bits) else $error("open bit read nonzero");

endmodule

`default_nettype wire

//--- ucr_host_model.sv
// Host model: the serial decoder side that writes and reads register words.
// Assumes sys_clk from the bench; requests change at the falling edge.
`timescale 1ns/1ps
`default_nettype none

module ucr_host_model (
	// Clock
	input  wire logic        sys_clk,
	// Register port toward the design
	output logic             wr_en,
	output logic [4:0]       wr_addr,
	output logic [47:0]      wr_data,
	output logic [4:0]       rd_addr,
	input  wire logic [47:0] rd_data
);
	// ************************************************************
	// Idle state of the port
	// ************************************************************
	initial begin
		wr_en = 1'b0;
		wr_addr = 5'h00;
		wr_data = 48'h0;
		rd_addr = 5'h00;
	end

	// One word per strobe; data shows its inverse once released
	task automatic write(input logic [4:0] a, input logic [47:0] d);
		@(negedge sys_clk);
		wr_en = 1'b1;
		wr_addr = a;
		wr_data = d;
		@(negedge sys_clk);
		wr_en = 1'b0;
		wr_data = ~d;
	endtask

	// Read data is registered, taken one edge after the address
	task automatic read(input logic [4:0] a, output logic [47:0] d);
		@(negedge sys_clk);
		rd_addr = a;
		@(negedge sys_clk);
		d = rd_data;
		rd_addr = ~a;
	endtask
endmodule

`default_nettype wire

//--- tb_upconverter_control_registers.sv
// Testbench for the upconverter control register slice.
// Assumes ucr_pkg, ucr_regs and ucr_host_model are compiled first.
`timescale 1ns/1ps
`default_nettype none

`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_errors++; \
	$display("mismatch at %0t: got %h expected %h", $time, (g), (e)); end end

module tb_upconverter_control_registers;
	logic                  sys_clk, rst_n, io_update, trig, key_pin;
	logic                  wr_en, auto_commit_pulse, ram_seg_load, amp_active, amp_auto_key;
	logic [4:0]            wr_addr, rd_addr;
	logic [47:0]           wr_data, rd_data, rd, s0, s1, d;
	logic [31:0]           ctl1, ctl2, r;
	logic [7:0]            dac_full_scale_current;
	logic [13:0]           amplitude_scale_factor;
	logic [15:0]           amp_ramp_rate;
	logic [1:0]            amp_step_size;
	ucr_pkg::ucr_clk_cfg_t clk_cfg;
	ucr_pkg::ucr_ram_seg_t ram_seg;
	int                    n_errors, checks, n, i, k;
	logic [4:0]            addrs [7] = '{5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h09, 5'h07};

	// ************************************************************
	// Clock, design and host
	// ************************************************************
	initial begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end

	ucr_regs ucr_regs_i (.sys_clk(sys_clk), .rst_n(rst_n), .wr_en(wr_en), .wr_addr(wr_addr),
		.wr_data(wr_data), .rd_addr(rd_addr), .rd_data(rd_data), .io_update(io_update),
		.control_function_one(ctl1), .control_function_two(ctl2), .ram_segment_trigger(trig),
		.amplitude_keying_pin(key_pin), .clk_cfg(clk_cfg), .dac_full_scale_current(dac_full_scale_current),
		.auto_commit_pulse(auto_commit_pulse), .ram_seg(ram_seg), .ram_seg_load(ram_seg_load),
		.amp_active(amp_active), .amp_auto_key(amp_auto_key), .amplitude_scale_factor(amplitude_scale_factor),
		.amp_ramp_rate(amp_ramp_rate), .amp_step_size(amp_step_size));

	ucr_host_model ucr_host_model_i (.sys_clk(sys_clk), .wr_en(wr_en), .wr_addr(wr_addr),
		.wr_data(wr_data), .rd_addr(rd_addr), .rd_data(rd_data));

	// ************************************************************
	// Expectations built from field positions
	// ************************************************************
	function automatic logic [47:0] rst_val(input logic [4:0] a);
		case (a)
			5'h02: rst_val = (48'h1 << 28) | (48'h7 << 24) | (48'h7 << 19) | (48'h1 << 14);
			5'h03: rst_val = 48'hff;
			5'h04: rst_val = 48'h0fff_ffff;
			default: rst_val = 48'h0;
		endcase
	endfunction

	function automatic logic [47:0] mask(input logic [4:0] a);
		case (a)
			5'h02: mask = (48'h3 << 28) | (48'h7 << 24) | (48'h7 << 19) | (48'h3 << 14) | (48'h1 << 8) | (48'h7f << 1);
			5'h03: mask = 48'hff;
			5'h05, 5'h06: mask = (48'hffff << 32) | (48'h3ff << 22) | (48'h3ff << 6) | 48'h7;
			5'h04, 5'h09: mask = 48'hffff_ffff;
			default: mask = 48'h0;
		endcase
	endfunction

	function automatic logic [31:0] amp_exp(input logic [31:0] c1, input logic pin, input logic [31:0] v);
		if (!c1[9])
			amp_exp = 32'h0;
		else if (c1[8])
			amp_exp = v;
		else if (c1[23] && !pin)
			amp_exp = 32'h0;
		else
			amp_exp = {16'h0, v[15:2], 2'b00};
	endfunction

	// ************************************************************
	// Helpers and verdict
	// ************************************************************
	task automatic cyc(input int c);
		repeat (c) @(negedge sys_clk);
	endtask

	task automatic commit();
		@(negedge sys_clk);
		io_update = 1'b1;
		@(negedge sys_clk);
		io_update = 1'b0;
	endtask

	task automatic wait_load();
		n = 0;
		while (ram_seg_load !== 1'b1 && n < 10) begin
			cyc(1);
			n++;
		end
	endtask

	task automatic give_verdict();
		$display("checks=%0d n_errors=%0d", checks, n_errors);
		if (n_errors == 0 && checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// Watchdog cuts a hang short
	initial begin
		repeat (20000) @(posedge sys_clk);
		n_errors++;
		$display("mismatch at %0t: watchdog expired", $time);
		give_verdict();
	end

	// ************************************************************
	// Main sequence
	// ************************************************************
	initial begin
		void'($urandom(75));
		n_errors = 0;
		checks = 0;
		{rst_n, io_update, trig, key_pin} = 4'h0;
		ctl1 = 32'h0;
		ctl2 = 32'h0;
		cyc(6);
		rst_n = 1'b1;
		// Reset values, unmapped address reads zero
		`CHK(clk_cfg, rst_val(5'h02) & 48'hffff_ffff)
		`CHK(dac_full_scale_current, 8'hff)
		for (i = 0; i < 7; i++) begin
			ucr_host_model_i.read(addrs[i], rd);
			`CHK(rd, rst_val(addrs[i]))
		end
		// Random and all-ones writes read back through the open-bit mask
		for (k = 0; k < 2; k++)
			for (i = 0; i < 7; i++) begin
				d = k ? 48'hffff_ffff_ffff : {16'($urandom), $urandom};
				ucr_host_model_i.write(addrs[i], d);
				ucr_host_model_i.read(addrs[i], rd);
				`CHK(rd, d & mask(addrs[i]))
			end
		// Buffered registers wait for the commit strobe
		d = {16'($urandom), $urandom};
		ucr_host_model_i.write(5'h02, d);
		ucr_host_model_i.write(5'h03, ~d);
		`CHK(clk_cfg, rst_val(5'h02) & 48'hffff_ffff)
		`CHK(dac_full_scale_current, 8'hff)
		commit();
		`CHK(clk_cfg, d[31:0] & mask(5'h02))
		`CHK(dac_full_scale_current, ~d[7:0])
		// Automatic commit pacing, period rate plus one
		ucr_host_model_i.write(5'h04, 48'h5);
		cyc(40);
		`CHK(auto_commit_pulse, 1'b0)
		ctl2[23] = 1'b1;
		wait_pulse: for (n = 0; n < 40 && auto_commit_pulse !== 1'b1; n++)
			cyc(1);
		n = 0;
		do begin
			cyc(1);
			n++;
		end while (auto_commit_pulse !== 1'b1 && n < 40);
		`CHK(n, 5 + 1)
		ctl2[23] = 1'b0;
		cyc(2);
		n = 0;
		repeat (30) begin
			cyc(1);
			n += int'(auto_commit_pulse === 1'b1);
		end
		`CHK(n, 0)
		// Segment descriptors on trigger edges
		s0 = {16'($urandom), $urandom};
		s1 = {16'($urandom), $urandom};
		ucr_host_model_i.write(5'h06, s1);
		commit();
		ucr_host_model_i.write(5'h06, ~s1);
		ucr_host_model_i.write(5'h05, s0);
		ctl1[31] = 1'b1;
		trig = 1'b1;
		wait_load();
		`CHK(ram_seg_load, 1'b1)
		`CHK(ram_seg, s0 & mask(5'h05))
		cyc(2);
		trig = 1'b0;
		wait_load();
		`CHK(ram_seg_load, 1'b1)
		`CHK(ram_seg, s1 & mask(5'h06))
		ctl1[31] = 1'b0;
		n = 0;
		for (i = 0; i < 24; i++) begin
			if (i % 6 == 0)
				trig = ~trig;
			cyc(1);
			n += int'(ram_seg_load === 1'b1);
		end
		`CHK(n, 0)
		// Amplitude register under every keying mode and pin level
		r = $urandom;
		ucr_host_model_i.write(5'h09, {16'h0, r});
		commit();
		for (k = 0; k < 16; k++) begin
			ctl1[9] = k[0];
			ctl1[8] = k[1];
			ctl1[23] = k[2];
			key_pin = k[3];
			cyc(4);
			`CHK({amp_ramp_rate, amplitude_scale_factor, amp_step_size}, amp_exp(ctl1, key_pin, r))
			`CHK({amp_active, amp_auto_key}, {k[0], k[0] & k[1]})
		end
		// Second reset in mid-run restores the defaults
		rst_n = 1'b0;
		cyc(2);
		rst_n = 1'b1;
		`CHK(dac_full_scale_current, 8'hff)
		ucr_host_model_i.read(5'h04, rd);
		`CHK(rd, rst_val(5'h04))
		give_verdict();
	end
endmodule

`undef CHK
`default_nettype wire
